// *** rtl/cwd_channel.sv ***
// Counter/watchdog channel with AXI4-Lite registers
`timescale 1ns/100ps
module cwd_channel
	import cwd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire cwd_axi_req_s axiReq,
	output cwd_axi_rsp_s axiRsp,
	input wire logic gateReloadIn,
	input wire logic eventClockIn,
	input wire logic triggerDirIn,
	output logic chanOut,
	output logic irqOut
);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] cwd_mask(input logic [31:0] v,
		input logic wide);
		cwd_mask = wide ? v : {16'h0000, v[15:0]};
	endfunction : cwd_mask

	function automatic logic [31:0] cwd_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				m[8*k +: 8] = d[8*k +: 8];
			end
		end
		cwd_merge = m;
	endfunction : cwd_merge

	// Internal rates; 20MHz rounds to 12 cycles, a small fast error
	function automatic logic [7:0] cwd_period(input logic [2:0] src);
		unique case (src)
			3'h0: cwd_period = 8'(CLK_KHZ / RATE0_KHZ);
			3'h1: cwd_period = 8'(CLK_KHZ / RATE1_KHZ);
			3'h2: cwd_period = 8'(CLK_KHZ / RATE2_KHZ);
			3'h3: cwd_period = 8'(CLK_KHZ / RATE3_KHZ);
			default: cwd_period = 8'(CLK_KHZ / RATE4_KHZ);
		endcase
	endfunction : cwd_period

	// ==========================================================
	// State
	cwd_state_s r;
	cwd_state_s n;
	logic [2:0] pinIn;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [2:0] mode;
	logic [2:0] src;
	logic [1:0] fa;
	logic [1:0] fb;
	logic [1:0] fc;
	logic isWd;
	logic isEv;
	logic wrCtl;
	logic wrLim;
	logic wrTrig;
	logic clrPend;
	logic [31:0] wVal;
	logic extTrig;
	logic trig;
	logic tick;
	logic gateOk;
	logic evGate;
	logic evEdge;
	logic reload;
	logic wdHit;
	logic evHit;
	logic [31:0] upVal;

	assign pinIn = {triggerDirIn, eventClockIn, gateReloadIn};

	always_comb begin
		n = r;
		rise = r.flt & ~r.fltD;
		fall = ~r.flt & r.fltD;
		mode = r.ctl[CTL_MODE_LSB +: 3];
		src = r.ctl[CTL_SRC_LSB +: 3];
		fa = r.ctl[CTL_A_LSB +: 2];
		fb = r.ctl[CTL_B_LSB +: 2];
		fc = r.ctl[CTL_C_LSB +: 2];
		isWd = mode == MODE_WD;
		isEv = mode == MODE_EV && src == SRC_EV;
		wrCtl = 1'b0;
		wrLim = 1'b0;
		wrTrig = 1'b0;
		clrPend = 1'b0;
		wVal = 32'h0000_0000;
		extTrig = 1'b0;
		trig = 1'b0;
		tick = 1'b0;
		gateOk = 1'b1;
		evGate = 1'b1;
		evEdge = 1'b0;
		reload = 1'b0;
		wdHit = 1'b0;
		evHit = 1'b0;
		upVal = 32'h0000_0000;

		// ======================================================
		// Input synchronisers and glitch filter
		n.fltD = r.flt;
		for (int i = 0; i < 3; i++) begin
			n.sy[i] = {r.sy[i][1:0], pinIn[i]};
			if (r.sy[i][1] != r.sy[i][2] || r.sy[i][2] == r.flt[i]) begin
				n.deb[i] = 10'h000;
			end else if (!r.ctl[CTL_DEB_BIT] || r.deb[i] == DEB_CYC) begin
				n.flt[i] = r.sy[i][2];
				n.deb[i] = 10'h000;
			end else begin
				n.deb[i] = r.deb[i] + 10'h001;
			end
		end

		// ======================================================
		// Register bus
		if (axiReq.awvalid && r.awRdy) begin
			n.awHeld = 1'b1;
			n.awA = axiReq.awaddr;
		end
		if (axiReq.wvalid && r.wRdy) begin
			n.wHeld = 1'b1;
			n.wD = axiReq.wdata;
			n.wS = axiReq.wstrb;
		end
		if (r.bvalid && axiReq.bready) begin
			n.bvalid = 1'b0;
		end
		if (r.awHeld && r.wHeld && !r.bvalid) begin
			n.awHeld = 1'b0;
			n.wHeld = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OK;
			unique case (r.awA)
				ADR_CTL: wrCtl = 1'b1;
				ADR_IST: clrPend = r.wS[0] && r.wD[0];
				ADR_LIM: wrLim = 1'b1;
				ADR_IEN: n.intEn = r.wS[0] ? r.wD[0] : r.intEn;
				ADR_TRIG: wrTrig = 1'b1;
				ADR_CNT: n.bresp = RESP_OK;
				default: n.bresp = RESP_ERR;
			endcase
		end
		if (wrCtl) begin
			wVal = cwd_merge({16'h0000, r.ctl}, r.wD, r.wS);
			n.ctl = wVal[15:0];
		end
		if (r.rvalid && axiReq.rready) begin
			n.rvalid = 1'b0;
		end
		if (axiReq.arvalid && r.arRdy) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OK;
			unique case (axiReq.araddr)
				ADR_CTL: n.rdata = {16'h0000, r.ctl};
				ADR_IST: n.rdata = {30'h0, r.run, r.pend};
				ADR_LIM: n.rdata = r.lim;
				ADR_CNT: n.rdata = r.cnt;
				ADR_IEN: n.rdata = {31'h0, r.intEn};
				default: begin
					n.rdata = 32'h0000_0000;
					n.rresp = RESP_ERR;
				end
			endcase
		end
		n.awRdy = !n.awHeld && !n.bvalid;
		n.wRdy = !n.wHeld && !n.bvalid;
		n.arRdy = !n.rvalid;

		// ======================================================
		// Trigger, count clock and gating
		extTrig = (fc == POL_LOW && fall[2])
			|| (fc == POL_HIGH && rise[2]);
		trig = wrTrig || extTrig;
		if (src == SRC_EXT) begin
			n.presc = 8'h00;
			tick = (fb == POL_LOW || fb == POL_HIGH) && rise[1];
		end else if (r.presc >= cwd_period(src) - 8'h01) begin
			n.presc = 8'h00;
			tick = 1'b1;
		end else begin
			n.presc = r.presc + 8'h01;
		end
		gateOk = fc != IN_GATE || r.flt[2];
		if (fa == POL_LOW) begin
			evGate = !r.flt[0];
			reload = !r.flt[0];
		end else if (fa == POL_HIGH) begin
			evGate = r.flt[0];
			reload = r.flt[0];
		end
		evEdge = (fb == POL_LOW && fall[1])
			|| (fb == POL_HIGH && rise[1]);

		// ======================================================
		// Counting
		n.pulse = r.pulse != 9'h000 ? r.pulse - 9'h001 : 9'h000;
		if (isWd) begin
			if (trig) begin
				if (r.cnt == 32'h0000_0000) begin
					n.run = 1'b0;
					wdHit = 1'b1;
				end else begin
					n.run = 1'b1;
				end
			end else if (r.run && tick && gateOk) begin
				n.cnt = r.cnt - 32'h0000_0001;
				if (r.cnt <= 32'h0000_0001) begin
					n.cnt = 32'h0000_0000;
					n.run = 1'b0;
					wdHit = 1'b1;
				end
			end
			if (reload) begin
				n.cnt = r.lim;
			end
		end else if (isEv) begin
			// Events are taken at the system clock; no count clock
			if (trig) begin
				n.run = 1'b1;
				n.cnt = 32'h0000_0000;
			end else if (r.run && evEdge && evGate) begin
				if (fc == IN_GATE && r.flt[2]) begin
					if (r.cnt != 32'h0000_0000) begin
						n.cnt = r.cnt - 32'h0000_0001;
					end
				end else begin
					upVal = cwd_mask(r.cnt + 32'h0000_0001,
						r.ctl[CTL_WIDE_BIT]);
					if (upVal == cwd_mask(r.lim, r.ctl[CTL_WIDE_BIT])) begin
						n.cnt = 32'h0000_0000;
						evHit = 1'b1;
						n.pulse = PULSE_CYC;
					end else begin
						n.cnt = upVal;
					end
				end
			end
		end else begin
			n.run = 1'b0;
		end
		if (wrLim) begin
			n.lim = cwd_merge(r.lim, r.wD, r.wS);
			n.cnt = n.lim;
		end
		// A new mode starts idle; the count and limit carry over from the old one
		if (wrCtl && n.ctl[CTL_MODE_LSB +: 3] != mode) begin
			n.run = 1'b0;
		end
		n.cnt = cwd_mask(n.cnt, n.ctl[CTL_WIDE_BIT]);

		// ======================================================
		// Interrupt and output pin
		// Set beats a same-cycle clear so no hit is lost
		n.pend = n.ctl[CTL_IE_BIT] && (((wdHit || evHit) && r.intEn)
			|| (r.pend && !clrPend));
		n.irq = n.pend;
		if ((isWd && n.run) || n.pulse != 9'h000) begin
			n.outPin = n.ctl[CTL_POL_BIT];
		end else begin
			n.outPin = !n.ctl[CTL_POL_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= ST_RST;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign axiRsp.awready = r.awRdy;
	assign axiRsp.wready = r.wRdy;
	assign axiRsp.bvalid = r.bvalid;
	assign axiRsp.bresp = r.bresp;
	assign axiRsp.arready = r.arRdy;
	assign axiRsp.rvalid = r.rvalid;
	assign axiRsp.rdata = r.rdata;
	assign axiRsp.rresp = r.rresp;
	assign chanOut = r.outPin;
	assign irqOut = r.irq;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence sPulseStart;
		$rose(r.pulse != 9'h000);
	endsequence

	sequence sPulseFull;
		r.pulse == PULSE_CYC ##1 r.pulse == PULSE_CYC - 9'h001;
	endsequence

	a_limit_load: assert property (wrLim |=>
		r.cnt == cwd_mask(r.lim, r.ctl[CTL_WIDE_BIT]))
		else $error("limit write did not load counter");

	a_pulse_len: assert property (sPulseStart and !evHit |-> sPulseFull
		or (sPulseStart ##1 r.pulse == PULSE_CYC))
		else $error("output pulse length wrong");

	a_event_wrap: assert property (evHit && !wrLim |=>
		r.cnt == 32'h0000_0000 && r.pulse == PULSE_CYC)
		else $error("event counter did not wrap at limit");

	a_pend_needs_ie: assert property (r.pend |-> r.ctl[CTL_IE_BIT]
		&& r.irq)
		else $error("interrupt pending without enable");

	a_wd_timeout: assert property ($fell(r.run)
		&& $past(isWd && !reload && !wrLim && !wrCtl)
		|-> r.cnt == 32'h0000_0000)
		else $error("watchdog stopped before zero");

	a_retrig_zero: assert property (isWd && trig && r.cnt == 32'h0
		&& !wrLim && !wrCtl |=> !r.run)
		else $error("watchdog ran without reload");

	a_gate_hold: assert property (isEv && r.run && !evGate && !trig
		&& !wrLim && !wrCtl |=> $stable(r.cnt))
		else $error("counter moved while gated off");

	a_width_narrow: assert property (!r.ctl[CTL_WIDE_BIT]
		|-> r.cnt[31:16] == 16'h0000)
		else $error("narrow counter has upper bits");

	a_out_idle: assert property (r.pulse == 9'h000 && !r.run
		|-> r.outPin != r.ctl[CTL_POL_BIT])
		else $error("output active while idle");

endmodule : cwd_channel

// *** include/cwd_pkg.sv ***
// Shared constants and types for the counter/watchdog channel
package cwd_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int CLK_KHZ = 250000;
	localparam int PULSE_NS = 1600;
	localparam int DEB_NS = 2400;
	localparam int MIN_EVENT_NS = 100;
	localparam logic [8:0] PULSE_CYC = 9'(PULSE_NS * CLK_MHZ / 1000);
	localparam logic [9:0] DEB_CYC = 10'(DEB_NS * CLK_MHZ / 1000);
	localparam int RATE0_KHZ = 1250;
	localparam int RATE1_KHZ = 2500;
	localparam int RATE2_KHZ = 5000;
	localparam int RATE3_KHZ = 10000;
	localparam int RATE4_KHZ = 20000;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADR_CTL = 8'h00;
	localparam logic [7:0] ADR_IST = 8'h04;
	localparam logic [7:0] ADR_LIM = 8'h08;
	localparam logic [7:0] ADR_CNT = 8'h0c;
	localparam logic [7:0] ADR_IEN = 8'h10;
	localparam logic [7:0] ADR_TRIG = 8'h34;

	// ==========================================================
	// Control field positions and codes
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_POL_BIT = 3;
	localparam int CTL_A_LSB = 4;
	localparam int CTL_B_LSB = 6;
	localparam int CTL_C_LSB = 8;
	localparam int CTL_SRC_LSB = 10;
	localparam int CTL_DEB_BIT = 13;
	localparam int CTL_WIDE_BIT = 14;
	localparam int CTL_IE_BIT = 15;
	localparam logic [2:0] MODE_WD = 3'h3;
	localparam logic [2:0] MODE_EV = 3'h4;
	localparam logic [2:0] SRC_EXT = 3'h5;
	localparam logic [2:0] SRC_EV = 3'h0;
	localparam logic [1:0] POL_LOW = 2'h1;
	localparam logic [1:0] POL_HIGH = 2'h2;
	localparam logic [1:0] IN_GATE = 2'h3;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// ==========================================================
	// Bus carriers
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} cwd_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cwd_axi_rsp_s;

	// ==========================================================
	// Channel state
	typedef struct packed {
		logic [15:0] ctl;
		logic [31:0] lim;
		logic [31:0] cnt;
		logic intEn;
		logic pend;
		logic run;
		logic [7:0] presc;
		logic [2:0][2:0] sy;
		logic [2:0] flt;
		logic [2:0] fltD;
		logic [2:0][9:0] deb;
		logic [8:0] pulse;
		logic outPin;
		logic irq;
		logic awRdy;
		logic wRdy;
		logic arRdy;
		logic awHeld;
		logic [7:0] awA;
		logic wHeld;
		logic [31:0] wD;
		logic [3:0] wS;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cwd_state_s;

	// Output idles inactive, high for the default active-low setting
	localparam cwd_state_s ST_RST = '{outPin: 1'b1, default: '0};

endpackage : cwd_pkg

// *** test/cwd_field_src.sv ***
// Model of the external source on the event input
`timescale 1ns/100ps
module cwd_field_src (
	input wire logic clk,
	input wire logic fireReq,
	input wire logic activeHigh,
	output logic evLine
);
	// ==========================================================
	// Event pulse generator
	// Held well past the minimum width so the sync chain sees it
	localparam int HOLD_CYC = 30;
	int holdCnt;
	always_ff @(posedge clk) begin
		if (fireReq) begin
			holdCnt <= HOLD_CYC;
		end else if (holdCnt > 0) begin
			holdCnt <= holdCnt - 1;
		end
	end
	assign evLine = (holdCnt > 0) ? activeHigh : !activeHigh;
endmodule : cwd_field_src

// *** test/tb_counter_watchdog_event_modes.sv ***
// Self-checking bench for the counter/watchdog channel
`timescale 1ns/100ps
module tb_counter_watchdog_event_modes
	import cwd_pkg::*;
;
	// ==========================================================
	// Signals
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0] resp;
	} cwd_row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	cwd_axi_req_s axiReq = '0;
	cwd_axi_rsp_s axiRsp;
	logic gateReloadIn = 1'b0;
	logic triggerDirIn = 1'b0;
	logic eventClockIn;
	logic fireReq = 1'b0;
	logic evHigh = 1'b1;
	logic chanOut;
	logic irqOut;
	logic [31:0] rd;
	logic [1:0] resp;
	int errors = 0;
	int numChecks = 0;
	int n;
	// Control word is 16 bits wide, upper half reads back as zero
	cwd_row_s rows [4] = '{
		'{ADR_CTL, 32'hffff1234, 32'h00001234, RESP_OK},
		'{ADR_LIM, 32'ha5a5a5a5, 32'ha5a5a5a5, RESP_OK},
		'{ADR_IEN, 32'h00000001, 32'h00000001, RESP_OK},
		'{8'h20, 32'h12345678, 32'h00000000, RESP_ERR}};

	// ==========================================================
	// Design and partner
	cwd_channel dut (.clk(clk), .rst(rst), .axiReq(axiReq),
		.axiRsp(axiRsp), .gateReloadIn(gateReloadIn),
		.eventClockIn(eventClockIn), .triggerDirIn(triggerDirIn),
		.chanOut(chanOut), .irqOut(irqOut));
	cwd_field_src src (.clk(clk), .fireReq(fireReq),
		.activeHigh(evHigh), .evLine(eventClockIn));

	always #2 clk = ~clk;

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		axiReq.awaddr <= a;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hf;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			if (axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiRsp.wready) axiReq.wvalid <= 1'b0;
			if (axiRsp.bvalid) break;
		end
		axiReq.bready <= 1'b0;
		resp = axiRsp.bresp;
		if (k == 200) errors++;
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a);
		int k;
		@(posedge clk);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			if (axiRsp.arready) axiReq.arvalid <= 1'b0;
			if (axiRsp.rvalid) break;
		end
		axiReq.rready <= 1'b0;
		rd = axiRsp.rdata;
		resp = axiRsp.rresp;
		if (k == 200) errors++;
	endtask : axiRead

	task automatic readChk(input logic [7:0] a, input logic [31:0] e);
		axiRead(a);
		check(rd, e);
	endtask : readChk

	task automatic fire();
		@(posedge clk);
		fireReq <= 1'b1;
		@(posedge clk);
		fireReq <= 1'b0;
	endtask : fire

	task automatic ev(input int k);
		repeat (k) begin
			fire();
			repeat (40) @(posedge clk);
		end
	endtask : ev

	// Bounded so a stuck output cannot hang the run
	task automatic waitOut(input logic lvl, output int c);
		c = 0;
		while (chanOut !== lvl && c < 2000) begin
			@(posedge clk);
			c++;
		end
	endtask : waitOut

	task automatic summarize();
		$display("checks=%0d errors=%0d", numChecks, errors);
		if (errors == 0 && numChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(chanOut, 1'b1);
		check(irqOut, 1'b0);
		readChk(ADR_CTL, 32'h0);
		foreach (rows[i]) begin
			axiWrite(rows[i].addr, rows[i].wdata);
			check(resp, rows[i].resp);
			axiRead(rows[i].addr);
			check(rd, rows[i].rdata);
			check(resp, rows[i].resp);
		end
		// Narrow counter keeps only the low half of the limit
		readChk(ADR_CNT, 32'h0000a5a5);
		axiWrite(ADR_CTL, 32'h5234);
		axiWrite(ADR_LIM, 32'ha5a5a5a5);
		readChk(ADR_CNT, 32'ha5a5a5a5);
		// Event counting, limit of two, wraps to zero
		axiWrite(ADR_LIM, 32'h2);
		axiWrite(ADR_IEN, 32'h0);
		axiWrite(ADR_CTL, 32'h8084);
		axiWrite(ADR_TRIG, 32'h0);
		ev(1);
		readChk(ADR_CNT, 32'h1);
		fire();
		waitOut(1'b0, n);
		check(n < 100, 1'b1);
		waitOut(1'b1, n);
		check(32'(n), 32'(PULSE_CYC));
		check(irqOut, 1'b0);
		readChk(ADR_CNT, 32'h0);
		axiWrite(ADR_IEN, 32'h1);
		ev(2);
		check(irqOut, 1'b1);
		axiWrite(ADR_IST, 32'h1);
		repeat (2) @(posedge clk);
		check(irqOut, 1'b0);
		ev(2);
		check(irqOut, 1'b1);
		axiWrite(ADR_CTL, 32'h0084);
		repeat (2) @(posedge clk);
		check(irqOut, 1'b0);
		// Short pulses are noise with debounce on
		axiWrite(ADR_CTL, 32'h2084);
		axiWrite(ADR_TRIG, 32'h0);
		ev(1);
		readChk(ADR_CNT, 32'h0);
		// Up then down, floor at zero
		axiWrite(ADR_CTL, 32'h0384);
		axiWrite(ADR_TRIG, 32'h0);
		ev(1);
		readChk(ADR_CNT, 32'h1);
		triggerDirIn <= 1'b1;
		ev(3);
		readChk(ADR_CNT, 32'h0);
		triggerDirIn <= 1'b0;
		// External trigger on a rising third input clears the count
		axiWrite(ADR_CTL, 32'h0284);
		ev(1);
		triggerDirIn <= 1'b1;
		repeat (10) @(posedge clk);
		readChk(ADR_CNT, 32'h0);
		triggerDirIn <= 1'b0;
		// Gate at active high
		axiWrite(ADR_CTL, 32'h00a4);
		axiWrite(ADR_TRIG, 32'h0);
		ev(2);
		readChk(ADR_CNT, 32'h0);
		gateReloadIn <= 1'b1;
		ev(1);
		readChk(ADR_CNT, 32'h1);
		gateReloadIn <= 1'b0;
		// Low events on a line that idles high
		evHigh <= 1'b0;
		axiWrite(ADR_CTL, 32'h0044);
		axiWrite(ADR_TRIG, 32'h0);
		ev(1);
		readChk(ADR_CNT, 32'h1);
		// Watchdog, active high, 20MHz tick of 12 cycles, five ticks
		axiWrite(ADR_CTL, 32'h100b);
		evHigh <= 1'b1;
		axiWrite(ADR_LIM, 32'h5);
		repeat (2) @(posedge clk);
		check(chanOut, 1'b0);
		axiWrite(ADR_TRIG, 32'h0);
		waitOut(1'b1, n);
		check(n < 20, 1'b1);
		waitOut(1'b0, n);
		check(n >= 48 && n <= 72, 1'b1);
		axiWrite(ADR_TRIG, 32'h0);
		repeat (4) @(posedge clk);
		check(chanOut, 1'b0);
		axiWrite(ADR_LIM, 32'h5);
		axiWrite(ADR_TRIG, 32'h0);
		repeat (30) @(posedge clk);
		axiWrite(ADR_LIM, 32'h5);
		waitOut(1'b0, n);
		check(n >= 40 && n <= 72, 1'b1);
		// Reload through the first input, then trigger again
		axiWrite(ADR_CTL, 32'h102b);
		gateReloadIn <= 1'b1;
		repeat (10) @(posedge clk);
		gateReloadIn <= 1'b0;
		repeat (10) @(posedge clk);
		readChk(ADR_CNT, 32'h5);
		axiWrite(ADR_TRIG, 32'h0);
		check(chanOut, 1'b1);
		repeat (20) @(posedge clk);
		// Reset again while the countdown runs
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(chanOut, 1'b1);
		check(irqOut, 1'b0);
		readChk(ADR_CTL, 32'h0);
		readChk(ADR_CNT, 32'h0);
		summarize();
	end

	// ==========================================================
	// Watchdog against a hung handshake
	initial begin
		#100000;
		errors++;
		summarize();
	end
endmodule : tb_counter_watchdog_event_modes
